// *** core/adc_ctrl_pkg.sv ***
/*
  Constants shared by the dual converter output control logic: register map,
  field positions, reset values and timing counts.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package adc_ctrl_pkg;
  localparam int DATA_WIDTH = 10;
  localparam int ADDR_WIDTH = 4;
  // Register byte offsets.
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] OFFSET_OFFSET = 4'h8;
  // Control register fields.
  localparam int CTRL_BUS_SELECT_BIT = 0;
  localparam int CTRL_FORMAT_BIT = 1;
  localparam int CTRL_STANDBY_BIT = 2;
  localparam int CTRL_POWER_DOWN_BIT = 3;
  localparam int CTRL_GAIN_BIT = 4;
  localparam int CTRL_OFFSET_TRIGGER_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  // Status register fields.
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_CORRECTING_BIT = 2;
  localparam int STATUS_FULL_BIT = 3;
  localparam int STATUS_EMPTY_BIT = 4;
  localparam int STATUS_OVERRUN_BIT = 5;
  // Offset register fields.
  localparam int OFFSET_FIRST_LSB = 0;
  localparam int OFFSET_SECOND_LSB = 16;
  // Timing.
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int STANDBY_RECOVERY_NS = 800;
  localparam int STANDBY_RECOVERY_CYCLES = STANDBY_RECOVERY_NS / CLOCK_PERIOD_NS;
  localparam int POWER_DOWN_RECOVERY_NS = 1000000;
  localparam int POWER_DOWN_RECOVERY_CYCLES = POWER_DOWN_RECOVERY_NS / CLOCK_PERIOD_NS;
  // Offset correction.
  localparam int CORRECTION_CYCLES = 34;
  localparam int AVERAGE_COUNT = 32;
  localparam int AVERAGE_SHIFT = 5;
  localparam int SETTLE_CYCLES = CORRECTION_CYCLES - AVERAGE_COUNT;
  localparam logic [DATA_WIDTH-1:0] MID_SCALE = 10'h200;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_STANDBY, PWR_DOWN, PWR_WAKE} power_state_type;
endpackage : adc_ctrl_pkg

// *** core/dual_adc_output_control.sv ***
/*
  Sample FIFO and the digital control and output logic of a dual converter.
  Assumes the converter cores deliver raw offset-binary codes on the system
  clock domain and that the sample clock arrives asynchronously on a pin.
*/
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_WIDTH = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_WIDTH-1:0] wr_ptr_r;
  logic [PTR_WIDTH-1:0] rd_ptr_r;
  logic [PTR_WIDTH:0] count_r;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << PTR_WIDTH) != DEPTH) begin : g_bad_depth
    $error("sample_fifo depth must be a power of two of at least two");
  end

  assign o_in_ready = (count_r != (PTR_WIDTH + 1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr_r];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : sample_fifo

module dual_adc_output_control #(
  parameter int FIFO_DEPTH = 8,
  parameter int POWER_DOWN_CYCLES = adc_ctrl_pkg::POWER_DOWN_RECOVERY_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Avalon-MM register slave
  input wire logic [adc_ctrl_pkg::ADDR_WIDTH-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Sample clock pin and raw converter codes
  input wire logic i_sample_clock,
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] i_first_raw,
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] i_second_raw,
  // Output buses
  output logic [adc_ctrl_pkg::DATA_WIDTH-1:0] o_first_channel_bus,
  output logic [adc_ctrl_pkg::DATA_WIDTH-1:0] o_second_channel_bus,
  output logic o_channel_indicator,
  // Analog front end controls
  output logic o_gain_high,
  output logic o_analog_active
);
  import adc_ctrl_pkg::*;

  localparam int WAKE_WIDTH = $clog2(POWER_DOWN_CYCLES + 1);
  localparam int ACC_WIDTH = DATA_WIDTH + AVERAGE_SHIFT;

  if (POWER_DOWN_CYCLES < STANDBY_RECOVERY_CYCLES) begin : g_bad_wake
    $error("power-down recovery must not be shorter than standby recovery");
  end

  // Control and status registers.
  logic [5:0] ctrl_r;
  logic overrun_r;
  logic bus_select;
  logic format_select;
  logic standby_request;
  logic power_down_request;
  logic offset_correct_trigger;
  assign bus_select = ctrl_r[CTRL_BUS_SELECT_BIT];
  assign format_select = ctrl_r[CTRL_FORMAT_BIT];
  assign standby_request = ctrl_r[CTRL_STANDBY_BIT];
  assign power_down_request = ctrl_r[CTRL_POWER_DOWN_BIT];
  assign offset_correct_trigger = ctrl_r[CTRL_OFFSET_TRIGGER_BIT];
  assign o_gain_high = ctrl_r[CTRL_GAIN_BIT];

  // Bus handshake: one wait state, then the answer.
  logic ack_r;
  logic bus_req;
  logic bus_write;
  logic [31:0] readdata_r;
  assign bus_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = bus_req && !ack_r;
  assign o_avs_readdata = readdata_r;
  assign bus_write = i_avs_write && ack_r;

  // Sample clock synchroniser; the level moves once stages two and three agree.
  logic [2:0] sclk_sync_r;
  logic sclk_level_r;
  logic sclk_agree;
  logic sclk_fall;
  logic sclk_rise;
  assign sclk_agree = (sclk_sync_r[1] == sclk_sync_r[2]);
  assign sclk_fall = sclk_agree && sclk_level_r && !sclk_sync_r[2];
  assign sclk_rise = sclk_agree && !sclk_level_r && sclk_sync_r[2];

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sclk_sync_r <= 3'h0;
      sclk_level_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], i_sample_clock};
      if (sclk_agree) begin
        sclk_level_r <= sclk_sync_r[2];
      end
    end
  end

  // Power state machine.
  power_state_type state_r;
  logic [WAKE_WIDTH-1:0] wake_count_r;
  logic active;
  assign active = (state_r == PWR_NORMAL);
  assign o_analog_active = active;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= PWR_NORMAL;
      wake_count_r <= '0;
    end else if (power_down_request) begin
      state_r <= PWR_DOWN;
    end else begin
      unique case (state_r)
        PWR_NORMAL: begin
          if (standby_request) begin
            state_r <= PWR_STANDBY;
          end
        end
        PWR_STANDBY: begin
          if (!standby_request) begin
            state_r <= PWR_WAKE;
            wake_count_r <= WAKE_WIDTH'(STANDBY_RECOVERY_CYCLES - 2);
          end
        end
        PWR_DOWN: begin
          state_r <= PWR_WAKE;
          wake_count_r <= WAKE_WIDTH'(POWER_DOWN_CYCLES - 2);
        end
        PWR_WAKE: begin
          if (wake_count_r == '0) begin
            state_r <= standby_request ? PWR_STANDBY : PWR_NORMAL;
          end else begin
            wake_count_r <= wake_count_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Offset correction sequence, shared counter, one accumulator per channel.
  logic trigger_prev_r;
  logic correcting_r;
  logic [5:0] cal_count_r;
  logic cal_start;
  logic cal_step;
  logic cal_last;
  logic sample_take;
  assign cal_start = offset_correct_trigger && !trigger_prev_r;
  assign sample_take = sclk_fall && active;
  assign cal_step = correcting_r && sample_take;
  assign cal_last = (cal_count_r == 6'(CORRECTION_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      trigger_prev_r <= 1'b0;
      correcting_r <= 1'b0;
      cal_count_r <= 6'h00;
    end else begin
      trigger_prev_r <= offset_correct_trigger;
      if (cal_start) begin
        correcting_r <= 1'b1;
        cal_count_r <= 6'h00;
      end else if (cal_step) begin
        cal_count_r <= cal_count_r + 1'b1;
        if (cal_last) begin
          correcting_r <= 1'b0;
        end
      end
    end
  end

  logic [DATA_WIDTH-1:0] raw [2];
  logic [DATA_WIDTH-1:0] corrected [2];
  logic signed [DATA_WIDTH:0] offset_r [2];
  assign raw[0] = i_first_raw;
  assign raw[1] = i_second_raw;

  for (genvar ch = 0; ch < 2; ch++) begin : g_channel
    logic [ACC_WIDTH-1:0] acc_r;
    logic [ACC_WIDTH-1:0] acc_sum;
    logic signed [DATA_WIDTH+1:0] diff;
    assign acc_sum = acc_r + ACC_WIDTH'(raw[ch]);
    assign diff = $signed({2'b00, raw[ch]}) - (DATA_WIDTH + 2)'(offset_r[ch]);

    always_comb begin
      if (diff < 0) begin
        corrected[ch] = '0;
      end else if (diff[DATA_WIDTH]) begin
        corrected[ch] = '1;
      end else begin
        corrected[ch] = diff[DATA_WIDTH-1:0];
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_srst) begin
        acc_r <= '0;
        offset_r[ch] <= '0;
      end else if (cal_start) begin
        acc_r <= '0;
      end else if (cal_step && cal_count_r >= 6'(SETTLE_CYCLES)) begin
        acc_r <= acc_sum;
        if (cal_last) begin
          offset_r[ch] <= $signed({1'b0, acc_sum[ACC_WIDTH-1:AVERAGE_SHIFT]})
            - $signed({1'b0, MID_SCALE});
        end
      end
    end
  end

  // Conversions wait in the FIFO; a full FIFO makes the sampler skip one.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [2*DATA_WIDTH-1:0] fifo_out_data;
  assign fifo_pop = sclk_rise && active;

  sample_fifo #(
    .WIDTH(2 * DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_in_valid(sample_take),
    .o_in_ready(fifo_in_ready),
    .i_in_data({corrected[1], corrected[0]}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  // Output coding: the format bit is read as each word leaves the FIFO, so both halves of a word share one coding.
  function automatic logic [DATA_WIDTH-1:0] code(input logic [DATA_WIDTH-1:0] value,
                                                  input logic twos);
    code = twos ? {~value[DATA_WIDTH-1], value[DATA_WIDTH-2:0]} : value;
  endfunction : code

  logic [DATA_WIDTH-1:0] second_held_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_first_channel_bus <= '0;
      o_second_channel_bus <= '0;
      o_channel_indicator <= 1'b0;
      second_held_r <= '0;
    end else if (fifo_pop && fifo_out_valid) begin
      // Bit 0 of each bus is the result LSB.
      o_first_channel_bus <= code(fifo_out_data[DATA_WIDTH-1:0], format_select);
      second_held_r <= code(fifo_out_data[2*DATA_WIDTH-1:DATA_WIDTH], format_select);
      o_second_channel_bus <= bus_select ?
        code(fifo_out_data[2*DATA_WIDTH-1:DATA_WIDTH], format_select) : '0;
      o_channel_indicator <= 1'b1;
    end else if (sclk_fall && o_channel_indicator) begin
      if (!bus_select) begin
        o_first_channel_bus <= second_held_r;
        o_second_channel_bus <= '0;
      end
      o_channel_indicator <= 1'b0;
    end else if (!bus_select) begin
      // Leaving parallel mode clears the second bus without waiting for a word.
      o_second_channel_bus <= '0;
    end
  end

  // Register file.
  logic overrun_set;
  assign overrun_set = sample_take && !fifo_in_ready;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ctrl_r <= CTRL_RESET;
      overrun_r <= 1'b0;
    end else begin
      if (bus_write && i_avs_address == CTRL_OFFSET && i_avs_byteenable[0]) begin
        ctrl_r <= i_avs_writedata[5:0];
      end
      if (overrun_set) begin
        overrun_r <= 1'b1;
      end else if (bus_write && i_avs_address == STATUS_OFFSET && i_avs_byteenable[0]
                   && i_avs_writedata[STATUS_OVERRUN_BIT]) begin
        overrun_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req && !ack_r;
      if (i_avs_read && !ack_r) begin
        readdata_r <= 32'h0000_0000;
        unique case (i_avs_address)
          CTRL_OFFSET: readdata_r[5:0] <= ctrl_r;
          STATUS_OFFSET: begin
            readdata_r[STATUS_STATE_LSB +: 2] <= state_r;
            readdata_r[STATUS_CORRECTING_BIT] <= correcting_r;
            readdata_r[STATUS_FULL_BIT] <= !fifo_in_ready;
            readdata_r[STATUS_EMPTY_BIT] <= !fifo_out_valid;
            readdata_r[STATUS_OVERRUN_BIT] <= overrun_r;
          end
          OFFSET_OFFSET: begin
            readdata_r[OFFSET_FIRST_LSB +: DATA_WIDTH + 1] <= offset_r[0];
            readdata_r[OFFSET_SECOND_LSB +: DATA_WIDTH + 1] <= offset_r[1];
          end
          default: readdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : dual_adc_output_control

// *** tb/adc_ctrl_assertions.sv ***
/* Concurrent checks on the ports of the dual converter output control block.
   Assumes the control register map of the shared package and a single clock. */
`timescale 1ns/1ps
module adc_ctrl_checker #(
  parameter int POWER_DOWN_CYCLES = 40
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register bus
  input wire logic [adc_ctrl_pkg::ADDR_WIDTH-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  // Outputs
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] o_first_channel_bus,
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] o_second_channel_bus,
  input wire logic o_channel_indicator,
  input wire logic o_gain_high,
  input wire logic o_analog_active
);
  import adc_ctrl_pkg::*;
  localparam int PD_MAX = POWER_DOWN_CYCLES + 4;
  logic [5:0] ctrl_r;
  logic [5:0] quiet_r;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // Mirror of the control register, updated on each accepted write.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ctrl_r <= CTRL_RESET;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == CTRL_OFFSET
                 && i_avs_byteenable[0]) begin
      ctrl_r <= i_avs_writedata[5:0];
    end
  end
  // Cycles since the last control change, so mode switches are not judged.
  always_ff @(posedge i_clock) begin
    if (i_srst || $changed(ctrl_r)) begin
      quiet_r <= 6'h00;
    end else if (quiet_r != 6'h28) begin
      quiet_r <= quiet_r + 6'h01;
    end
  end
  a_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("more than one wait state");
  a_mux_zero: assert property (!ctrl_r[0] [*3] |-> o_second_channel_bus == '0)
    else $error("second bus not low in multiplexed mode");
  a_gain_follow: assert property ($stable(ctrl_r[4]) [*2]
    |-> o_gain_high == ctrl_r[4]) else $error("gain output differs from control");
  a_power_off: assert property ((ctrl_r[2] || ctrl_r[3]) [*3]
    |-> !o_analog_active) else $error("active while standby or power-down");
  a_standby_wake: assert property ($fell(ctrl_r[2]) && !ctrl_r[3] && !$past(ctrl_r[3])
    |-> ##[1:16] o_analog_active) else $error("late standby recovery");
  a_pd_wake: assert property ($fell(ctrl_r[3]) && !ctrl_r[2]
    |-> ##[1:PD_MAX] o_analog_active) else $error("late power-down recovery");
  a_ind_rise: assert property (quiet_r == 6'h28 && ctrl_r[0]
    && $changed(o_first_channel_bus) |-> $rose(o_channel_indicator))
    else $error("parallel data change without strobe");
  a_mux_toggle: assert property (quiet_r == 6'h28 && !ctrl_r[0]
    && $changed(o_first_channel_bus) |-> $changed(o_channel_indicator))
    else $error("multiplexed word change without indicator edge");
  c_par_word: cover property (ctrl_r[0] && $rose(o_channel_indicator));
  c_mux_word: cover property (!ctrl_r[0] && $fell(o_channel_indicator));
  c_pd_exit: cover property ($fell(ctrl_r[3]));
endmodule : adc_ctrl_checker

bind dual_adc_output_control adc_ctrl_checker #(.POWER_DOWN_CYCLES(POWER_DOWN_CYCLES)) chk_i (
  .i_clock, .i_srst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_waitrequest, .o_first_channel_bus, .o_second_channel_bus,
  .o_channel_indicator, .o_gain_high, .o_analog_active);

// *** tb/sample_capture_model.sv ***
/* Downstream capture logic: takes words off the output buses using the indicator.
   Assumes registered device outputs on the same system clock. */
`timescale 1ns/1ps
module sample_capture_model (
  // Clock and mode
  input wire logic i_clock,
  input wire logic i_mux,
  // Device outputs
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] i_first_bus,
  input wire logic [adc_ctrl_pkg::DATA_WIDTH-1:0] i_second_bus,
  input wire logic i_indicator,
  // Captured words
  output logic [adc_ctrl_pkg::DATA_WIDTH-1:0] o_first_word,
  output logic [adc_ctrl_pkg::DATA_WIDTH-1:0] o_second_word,
  output int o_count
);
  import adc_ctrl_pkg::*;
  logic ind_r = 1'b0;
  initial o_count = 0;
  always @(posedge i_clock) begin
    ind_r <= i_indicator;
    if (i_indicator && !ind_r) begin
      o_first_word <= i_first_bus;
      if (!i_mux) begin
        o_second_word <= i_second_bus;
        o_count <= o_count + 1;
      end
    end
    if (i_mux && !i_indicator && ind_r) begin
      o_second_word <= i_first_bus;
      o_count <= o_count + 1;
    end
  end
endmodule : sample_capture_model

// *** tb/tb_top.sv ***
/* Self-checking bench for the dual converter output control block and its FIFO.
   Assumes a sample clock of 16 system clocks and the shared register map. */
`timescale 1ns/1ps
module tb_top;
  import adc_ctrl_pkg::*;
  localparam int PD_CYC = 40;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [3:0] be = 4'hF;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  logic wait_req, ind, gain, active;
  logic sclk = 1'b0;
  logic mux = 1'b0;
  logic [3:0] sc_cnt = 4'h0;
  logic [9:0] raw1 = 10'h0;
  logic [9:0] raw2 = 10'h0;
  logic [9:0] bus1, bus2, cap1, cap2;
  int cap_n;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 i_clock = ~i_clock;
  dual_adc_output_control #(.FIFO_DEPTH(8), .POWER_DOWN_CYCLES(PD_CYC)) uut (
    .i_clock, .i_srst, .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_sample_clock(sclk), .i_first_raw(raw1),
    .i_second_raw(raw2), .o_first_channel_bus(bus1), .o_second_channel_bus(bus2),
    .o_channel_indicator(ind), .o_gain_high(gain), .o_analog_active(active));
  sample_capture_model cap (.i_clock, .i_mux(mux), .i_first_bus(bus1), .i_second_bus(bus2),
    .i_indicator(ind), .o_first_word(cap1), .o_second_word(cap2), .o_count(cap_n));
  always @(posedge i_clock) begin
    sc_cnt <= sc_cnt + 4'h1;
    sclk <= sc_cnt[3];
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    // Waitrequest and read data are looked at between edges, where they have settled.
    @(negedge i_clock);
    while (wait_req) @(negedge i_clock);
    q = rdata;
    @(posedge i_clock);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wait_words(input int n);
    int t;
    t = cap_n + n;
    while (cap_n < t) @(posedge i_clock);
  endtask : wait_words
  task automatic t_regs;
    bus(1'b0, CTRL_OFFSET, 32'h0);
    check(q, 32'(CTRL_RESET));
    bus(1'b0, 4'hC, 32'h0);
    check(q, 32'h0);
    be <= 4'h0;
    bus(1'b1, CTRL_OFFSET, 32'h0);
    be <= 4'hF;
    bus(1'b0, CTRL_OFFSET, 32'h0);
    check(q, 32'(CTRL_RESET));
  endtask : t_regs
  task automatic t_stream;
    raw1 <= 10'h301;
    raw2 <= 10'h0C2;
    wait_words(3);
    check(32'(cap1), 32'h301);
    check(32'(cap2), 32'h0C2);
    bus(1'b1, CTRL_OFFSET, 32'h3);
    wait_words(3);
    check(32'(cap1), 32'h101);
    check(32'(cap2), 32'h2C2);
    bus(1'b1, CTRL_OFFSET, 32'h0);
    mux <= 1'b1;
    wait_words(3);
    check(32'(cap1), 32'h301);
    check(32'(cap2), 32'h0C2);
    check(32'(bus2), 32'h0);
    bus(1'b1, CTRL_OFFSET, 32'h1);
    mux <= 1'b0;
  endtask : t_stream
  task automatic t_power;
    bus(1'b1, CTRL_OFFSET, 32'h11);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(gain), 32'h1);
    bus(1'b1, CTRL_OFFSET, 32'h5);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[1:0]), 32'h1);
    check(32'(active), 32'h0);
    bus(1'b1, CTRL_OFFSET, 32'h1);
    repeat (STANDBY_RECOVERY_CYCLES + 1) @(posedge i_clock);
    check(32'(active), 32'h1);
    check(32'(gain), 32'h0);
    bus(1'b1, CTRL_OFFSET, 32'hD);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[1:0]), 32'h2);
    bus(1'b1, CTRL_OFFSET, 32'h1);
    repeat (PD_CYC + 2) @(posedge i_clock);
    check(32'(active), 32'h1);
  endtask : t_power
  task automatic t_offset;
    raw1 <= 10'h210;
    raw2 <= 10'h1F0;
    bus(1'b1, CTRL_OFFSET, 32'h21);
    repeat (16 * 30) @(posedge i_clock);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[2]), 32'h1);
    repeat (16 * 6) @(posedge i_clock);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[2]), 32'h0);
    bus(1'b0, OFFSET_OFFSET, 32'h0);
    check(32'(q[10:0]), 32'h010);
    check(32'(q[26:16]), 32'h7F0);
    bus(1'b1, CTRL_OFFSET, 32'h1);
    wait_words(3);
    check(32'(cap1), 32'h200);
    check(32'(cap2), 32'h200);
  endtask : t_offset
  task automatic t_fifo;
    // Right after a pop the FIFO stays empty until the next sample clock fall pushes.
    @(posedge ind);
    @(posedge i_clock);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[STATUS_EMPTY_BIT]), 32'h1);
    check(32'(q[STATUS_FULL_BIT]), 32'h0);
    check(32'(q[STATUS_OVERRUN_BIT]), 32'h0);
    // The indicator falls on the edge that pushes the next conversion.
    @(negedge ind);
    @(posedge i_clock);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[STATUS_EMPTY_BIT]), 32'h0);
    check(32'(q[STATUS_FULL_BIT]), 32'h0);
    bus(1'b1, STATUS_OFFSET, 32'h20);
    bus(1'b0, STATUS_OFFSET, 32'h0);
    check(32'(q[STATUS_OVERRUN_BIT]), 32'h0);
  endtask : t_fifo
  initial begin
    repeat (5) @(posedge i_clock);
    i_srst <= 1'b0;
    t_regs();
    t_stream();
    t_power();
    t_offset();
    t_fifo();
    end_of_test();
  end
endmodule : tb_top
